/* File: cmd_pkg.sv */
/*
  Constants and carrier types for the core's decode, branch timing and
  memory-space mapping block.
  Assumes an 8-bit core with a 16-bit program counter and 8-bit data space.
*/
package cmd_pkg;

  // ==========================================================
  // Opcodes handled by the decoder
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_SPARE = 8'hA5;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_RETI = 8'h32;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JMP_IND = 8'h73;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_CJNE_DIR = 8'hB5;
  localparam logic [7:0] OP_CJNE_IMM = 8'hB4;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hD5;
  localparam logic [7:0] OP_CPL_C = 8'hB3;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_ANL_BIT = 8'h82;
  localparam logic [7:0] OP_ANL_NBIT = 8'hB0;
  localparam logic [7:0] OP_ORL_BIT = 8'h72;
  localparam logic [7:0] OP_ORL_NBIT = 8'hA0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'hA2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_SETB_BIT = 8'hD2;
  // Opcode families matched on a field
  localparam logic [4:0] OP_AJMP_LO = 5'h01;
  localparam logic [4:0] OP_ACALL_LO = 5'h11;
  localparam logic [6:0] OP_CJNE_RI_HI = 7'h5B;
  localparam logic [4:0] OP_CJNE_RN_HI = 5'h17;
  localparam logic [4:0] OP_DJNZ_RN_HI = 5'h1B;

  // ==========================================================
  // Lengths in bytes and counts of clock cycles
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_5 = 3'h5;

  // ==========================================================
  // Memory map
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam logic [15:0] FLASH_TOP_8K = 16'h1DFF;
  localparam logic [15:0] FLASH_TOP_4K = 16'h0FFF;
  localparam logic [15:0] FLASH_TOP_2K = 16'h07FF;
  localparam int BANK_LO_BIT = 3;
  localparam int BANK_HI_BIT = 4;

  // ==========================================================
  // Carriers
  typedef enum logic [1:0] {CMD_LOW_RAM, CMD_UP_RAM, CMD_FUNC_REG} cmd_space_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } cmd_instr_t;

  typedef struct packed {
    logic carry;
    logic acc_zero;
    logic bit_val;
    logic cmp_ne;
    logic dec_nz;
    logic [7:0] acc;
    logic [15:0] data_pointer;
  } cmd_cond_t;

  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cycles;
    logic branch;
    logic taken;
    logic [15:0] target;
    logic bit_op;
    logic bit_clear;
    logic call;
    logic ret;
  } cmd_dec_t;

  typedef struct packed {
    logic valid;
    logic indirect;
    logic bit_op;
    logic ri;
    logic [7:0] addr;
  } cmd_dreq_t;

  typedef struct packed {
    logic valid;
    cmd_space_t space;
    logic [7:0] byte_addr;
    logic [2:0] bit_pos;
    logic bit_op;
    logic [7:0] ptr_addr;
  } cmd_dmap_t;

  typedef struct packed {
    logic valid;
    logic movx_wr;
    logic [15:0] addr;
  } cmd_creq_t;

  typedef struct packed {
    logic valid;
    logic in_flash;
    logic reserved;
    logic code_wr;
    logic data_wr;
  } cmd_cmap_t;

endpackage : cmd_pkg

/* File: cmd_core.sv */
/*
  Instruction timing decoder, branch target former, data and program
  memory-space mapper and stack pointer of the 8-bit core.
  Assumes the fetch unit, ALU, RAM and flash sit on the same clock and
  supply condition flags and operand bytes alongside each issue.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - Carry branches: two bytes, two cycles falling through, three taken.
// - Bit branches: three bytes, three or four cycles; test-and-clear clears set bit.
// - Carry logic with a direct bit takes two bytes, two cycles; carry complement one.
// - Page call: two bytes, three cycles; long call: three bytes, four cycles.
// - Both returns are one byte and five cycles.
// - Page, short relative and indirect jumps take three cycles; long jump four.
// - Compare-branch three or four cycles; indirect operand form four or five.
// - Decrement-branch: two or three on a register, three or four direct.
// - Accumulator zero branches: two bytes, two or three cycles.
// - No-operation and the spare opcode both take one byte, one cycle.
// - Relative target is next-instruction address plus signed 8-bit displacement.
// - Page target keeps upper five bits of the next-instruction address.
// - Flash runs from zero to the variant top; higher addresses are reserved.
// - With program-store write enable set, external writes go to program memory.
// - 256 bytes of RAM; lower half reachable directly and indirectly.
// - Above 0x7F direct goes to function registers, indirect to upper RAM.
// - Bytes zero to 0x1F form four banks, picked by status bits 3 and 4.
// - Indirect pointer is R0 or R1 of the selected bank.
// - Bit addresses below 0x80 map onto bytes 0x20 to 0x2F.
// - Bit or byte access follows the instruction's operand type only.
// - Stack pointer resets to 0x07; push increments first, then writes.
// - Only function registers at addresses ending 0 or 8 hold bits.
module cmd_core #(
  parameter logic [15:0] FLASH_TOP = cmd_pkg::FLASH_TOP_8K
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_issue,
  input wire cmd_pkg::cmd_instr_t i_instr,
  input wire cmd_pkg::cmd_cond_t i_cond,
  output logic o_ready,
  output logic o_done,
  output cmd_pkg::cmd_dec_t o_dec,
  input wire logic [7:0] i_program_status_word,
  input wire cmd_pkg::cmd_dreq_t i_dreq,
  output cmd_pkg::cmd_dmap_t o_dmap,
  input wire logic i_program_store_control,
  input wire cmd_pkg::cmd_creq_t i_creq,
  output cmd_pkg::cmd_cmap_t o_cmap,
  input wire logic i_push,
  input wire logic i_pop,
  output logic o_push_wr,
  output logic [7:0] o_stack_pointer
);
  import cmd_pkg::*;

  // ==========================================================
  // Decode of the instruction being issued
  cmd_dec_t nd;
  logic [15:0] pcn;
  logic [7:0] rel;
  logic cbr;
  logic cond;
  logic use_rel;
  logic use_page;
  logic [2:0] base;

  always_comb begin
    nd = '0;
    nd.len = LEN_1;
    base = CYC_1;
    rel = i_instr.op1;
    cbr = 1'b0;
    cond = 1'b0;
    use_rel = 1'b0;
    use_page = 1'b0;
    if (i_instr.opcode[4:0] == OP_AJMP_LO || i_instr.opcode[4:0] == OP_ACALL_LO) begin
      nd.len = LEN_2;
      base = CYC_3;
      use_page = 1'b1;
      nd.call = i_instr.opcode[4];
    end else begin
      case (i_instr.opcode)
        OP_LJMP, OP_LCALL: begin
          nd.len = LEN_3;
          base = CYC_4;
          nd.target = {i_instr.op1, i_instr.op2};
          nd.call = (i_instr.opcode == OP_LCALL);
        end
        OP_RET, OP_RETI: begin
          base = CYC_5;
          nd.ret = 1'b1;
        end
        OP_SJMP: begin
          nd.len = LEN_2;
          base = CYC_3;
          use_rel = 1'b1;
        end
        OP_JMP_IND: begin
          base = CYC_3;
          nd.target = i_cond.data_pointer + {8'h00, i_cond.acc};
        end
        OP_JC, OP_JNC: begin
          nd.len = LEN_2;
          base = CYC_2;
          cbr = 1'b1;
          cond = i_cond.carry ^ (i_instr.opcode == OP_JNC);
        end
        OP_JZ, OP_JNZ: begin
          nd.len = LEN_2;
          base = CYC_2;
          cbr = 1'b1;
          cond = i_cond.acc_zero ^ (i_instr.opcode == OP_JNZ);
        end
        OP_JB, OP_JNB, OP_JBC: begin
          nd.len = LEN_3;
          base = CYC_3;
          cbr = 1'b1;
          rel = i_instr.op2;
          nd.bit_op = 1'b1;
          cond = i_cond.bit_val ^ (i_instr.opcode == OP_JNB);
          // A set bit is cleared whether or not anything else happens
          nd.bit_clear = (i_instr.opcode == OP_JBC) && i_cond.bit_val;
        end
        OP_CJNE_DIR, OP_CJNE_IMM: begin
          nd.len = LEN_3;
          base = CYC_3;
          cbr = 1'b1;
          rel = i_instr.op2;
          cond = i_cond.cmp_ne;
        end
        OP_DJNZ_DIR: begin
          nd.len = LEN_3;
          base = CYC_3;
          cbr = 1'b1;
          rel = i_instr.op2;
          cond = i_cond.dec_nz;
        end
        OP_CPL_BIT, OP_ANL_BIT, OP_ANL_NBIT, OP_ORL_BIT, OP_ORL_NBIT,
        OP_MOV_C_BIT, OP_MOV_BIT_C, OP_CLR_BIT, OP_SETB_BIT: begin
          nd.len = LEN_2;
          base = CYC_2;
          nd.bit_op = 1'b1;
        end
        default: begin
          if (i_instr.opcode[7:1] == OP_CJNE_RI_HI) begin
            nd.len = LEN_3;
            base = CYC_4;
            cbr = 1'b1;
            rel = i_instr.op2;
            cond = i_cond.cmp_ne;
          end else if (i_instr.opcode[7:3] == OP_CJNE_RN_HI) begin
            nd.len = LEN_3;
            base = CYC_3;
            cbr = 1'b1;
            rel = i_instr.op2;
            cond = i_cond.cmp_ne;
          end else if (i_instr.opcode[7:3] == OP_DJNZ_RN_HI) begin
            nd.len = LEN_2;
            base = CYC_2;
            cbr = 1'b1;
            cond = i_cond.dec_nz;
          end
          // No-op, spare opcode, carry complement and all others: 1/1
        end
      endcase
    end
    pcn = i_instr.pc + {14'h0000, nd.len};
    if (use_rel || cbr) begin
      nd.target = pcn + {{8{rel[7]}}, rel};
    end
    if (use_page) begin
      nd.target = {pcn[15:11], i_instr.opcode[7:5], i_instr.op1};
    end
    nd.branch = cbr || use_rel || use_page || nd.ret || (nd.target != 16'h0000) ||
                (i_instr.opcode == OP_LJMP) || (i_instr.opcode == OP_LCALL);
    nd.taken = cbr ? cond : nd.branch;
    // Taken adds exactly one cycle to the fall-through count
    nd.cycles = base + {2'b00, cbr && cond};
  end

  // ==========================================================
  // Execution sequencer: counts out the cycles of each instruction
  typedef enum logic {CMD_IDLE, CMD_EXEC} cmd_state_t;
  cmd_state_t state_q;
  cmd_state_t state_d;
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  cmd_dec_t dec_q;
  cmd_dec_t dec_d;
  logic take;

  assign o_done = (state_q == CMD_EXEC) && (cnt_q == 3'h0);
  assign o_ready = (state_q == CMD_IDLE) || o_done;
  assign take = i_issue && o_ready;
  assign o_dec = dec_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    dec_d = dec_q;
    case (state_q)
      CMD_IDLE: begin
        state_d = CMD_IDLE;
      end
      CMD_EXEC: begin
        if (cnt_q != 3'h0) begin
          cnt_d = cnt_q - 3'h1;
        end else begin
          state_d = CMD_IDLE;
        end
      end
      default: begin
        state_d = CMD_IDLE;
      end
    endcase
    // Back-to-back issue lands in the last cycle of the previous one
    if (take) begin
      state_d = CMD_EXEC;
      cnt_d = nd.cycles - 3'h1;
      dec_d = nd;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q <= CMD_IDLE;
      cnt_q <= 3'h0;
      dec_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      dec_q <= dec_d;
    end
  end

  // ==========================================================
  // Data space mapping
  cmd_dmap_t dmap_d;
  cmd_dmap_t dmap_q;
  logic [1:0] bank;

  assign o_dmap = dmap_q;

  always_comb begin
    bank = {i_program_status_word[BANK_HI_BIT], i_program_status_word[BANK_LO_BIT]};
    dmap_d = '0;
    dmap_d.valid = i_dreq.valid;
    dmap_d.bit_op = i_dreq.bit_op;
    dmap_d.ptr_addr = {3'b000, bank, 2'b00, i_dreq.ri};
    dmap_d.bit_pos = i_dreq.addr[2:0];
    dmap_d.byte_addr = i_dreq.addr;
    dmap_d.space = CMD_LOW_RAM;
    if (i_dreq.bit_op) begin
      if (i_dreq.addr[7]) begin
        dmap_d.space = CMD_FUNC_REG;
        dmap_d.byte_addr = {i_dreq.addr[7:3], 3'b000};
      end else begin
        dmap_d.byte_addr = BIT_RAM_BASE + {4'h0, i_dreq.addr[6:3]};
      end
    end else if (i_dreq.addr[7]) begin
      dmap_d.space = i_dreq.indirect ? CMD_UP_RAM : CMD_FUNC_REG;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dmap_q <= '0;
    end else begin
      dmap_q <= dmap_d;
    end
  end

  // ==========================================================
  // Program space mapping and write steering
  cmd_cmap_t cmap_d;
  cmd_cmap_t cmap_q;

  assign o_cmap = cmap_q;

  always_comb begin
    cmap_d.valid = i_creq.valid;
    cmap_d.in_flash = (i_creq.addr <= FLASH_TOP);
    cmap_d.reserved = (i_creq.addr > FLASH_TOP);
    // Flash stays read-only until software opens the write path
    cmap_d.code_wr = i_creq.valid && i_creq.movx_wr && i_program_store_control;
    cmap_d.data_wr = i_creq.valid && i_creq.movx_wr && !i_program_store_control;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cmap_q <= '0;
    end else begin
      cmap_q <= cmap_d;
    end
  end

  // ==========================================================
  // Stack pointer
  logic [7:0] sp_d;
  logic [7:0] sp_q;
  logic push_d;
  logic push_q;

  assign o_stack_pointer = sp_q;
  assign o_push_wr = push_q;

  always_comb begin
    sp_d = sp_q;
    push_d = i_push;
    // Push wins over a simultaneous pop; the bench raises both together once in t_stack
    if (i_push) begin
      sp_d = sp_q + 8'h01;
    end else if (i_pop) begin
      sp_d = sp_q - 8'h01;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sp_q <= SP_RESET;
      push_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      push_q <= push_d;
    end
  end

  // ==========================================================
  // Checks
  carry_branch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode == OP_JC && i_cond.carry |-> ##1 !o_done ##1 !o_done ##1 o_done)
    else $error("taken carry branch not three cycles");
  bit_branch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode == OP_JBC && i_cond.bit_val |=> o_dec.bit_clear && o_dec.len == 2'h3 ##3 o_done)
    else $error("test-and-clear branch wrong");
  cpl_carry_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode == OP_CPL_C |=> o_done && o_dec.len == 2'h1)
    else $error("carry complement not one cycle");
  long_call_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode == OP_LCALL |=> o_dec.len == 2'h3 && o_dec.call ##3 o_done)
    else $error("long call timing wrong");
  return_time_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode == OP_RETI |-> ##1 !o_done [*4] ##1 o_done)
    else $error("return not five cycles");
  cjne_fall_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode[7:1] == OP_CJNE_RI_HI && !i_cond.cmp_ne |-> ##4 o_done && !o_dec.taken)
    else $error("indirect compare fall-through not four cycles");
  djnz_reg_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode[7:3] == OP_DJNZ_RN_HI && !i_cond.dec_nz |-> ##2 o_done)
    else $error("register decrement fall-through not two cycles");
  rel_target_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode == OP_SJMP |=>
      o_dec.target == $past(pcn) + {{8{$past(rel[7])}}, $past(rel)})
    else $error("relative target wrong");
  page_target_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    take && i_instr.opcode[4:0] == OP_AJMP_LO |=> o_dec.target[15:11] == $past(pcn[15:11]))
    else $error("page target left the page");
  upper_ram_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_dreq.indirect && !i_dreq.bit_op && i_dreq.addr[7] |=> o_dmap.space == CMD_UP_RAM)
    else $error("indirect high access not in upper RAM");
  stack_push_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_push |=> o_push_wr && o_stack_pointer == $past(o_stack_pointer) + 8'h01)
    else $error("push did not increment first");

endmodule : cmd_core

/* File: cmd_mem_model.sv */
/*
  Behavioural program flash and internal data RAM on the far side of the core.
  Assumes the core's stack and code-map outputs share its clock and that the
  write byte is held by the bench while a write is under way.
*/
`timescale 1ns/100ps
module cmd_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_push_wr,
  input wire logic [7:0] i_stack_pointer,
  input wire cmd_pkg::cmd_cmap_t i_cmap,
  input wire logic [15:0] i_code_addr,
  input wire logic [7:0] i_wdata
);
  import cmd_pkg::*;
  // ==========================================================
  // Storage
  logic [7:0] low_ram [128];
  // Upper half is its own array: function registers never alias it
  logic [7:0] up_ram [128];
  logic [7:0] flash [8192];
  logic [15:0] addr_q;

  // ==========================================================
  // Writes
  // Code map answers one cycle late, so its address is delayed to match
  always_ff @(posedge i_ref_clk) begin
    addr_q <= i_code_addr;
    if (i_push_wr) begin
      if (i_stack_pointer[7]) begin
        up_ram[i_stack_pointer[6:0]] <= i_wdata;
      end else begin
        low_ram[i_stack_pointer[6:0]] <= i_wdata;
      end
    end
    if (i_cmap.code_wr && i_cmap.in_flash) begin
      flash[addr_q[12:0]] <= i_wdata;
    end
  end
endmodule : cmd_mem_model

/* File: tb_top.sv */
/*
  Self-checking bench for the decode, branch timing and memory-map core.
  Assumes the core's default flash size and its inline assertions.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t act=%0h exp=%0h", $time, (a), (e)); end end
module tb_top;
  import cmd_pkg::*;
  logic clk, i_rst_b, i_issue, o_ready, o_done, i_push, i_pop, o_push_wr, ctl;
  cmd_instr_t i_instr;
  cmd_cond_t i_cond;
  cmd_dec_t o_dec;
  logic [7:0] program_status_word, o_sp, wd;
  cmd_dreq_t i_dreq;
  cmd_dmap_t o_dmap;
  cmd_creq_t i_creq;
  cmd_cmap_t o_cmap;
  int n_mismatch = 0;
  int num_checks = 0;
  localparam logic [15:0] P = 16'h1234;

  cmd_core i_dut (.i_ref_clk(clk), .i_rst_b(i_rst_b), .i_issue(i_issue), .i_instr(i_instr),
    .i_cond(i_cond), .o_ready(o_ready), .o_done(o_done), .o_dec(o_dec),
    .i_program_status_word(program_status_word), .i_dreq(i_dreq), .o_dmap(o_dmap),
    .i_program_store_control(ctl), .i_creq(i_creq), .o_cmap(o_cmap), .i_push(i_push),
    .i_pop(i_pop), .o_push_wr(o_push_wr), .o_stack_pointer(o_sp));
  cmd_mem_model i_mem (.i_ref_clk(clk), .i_push_wr(o_push_wr), .i_stack_pointer(o_sp),
    .i_cmap(o_cmap), .i_code_addr(i_creq.addr), .i_wdata(wd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  function automatic logic [15:0] rel(input logic [15:0] pc, input logic [1:0] len, input logic [7:0] d);
    return pc + {14'h0000, len} + {{8{d[7]}}, d};
  endfunction : rel

  // Counts cycles from take to done; f = carry, acc_zero, bit_val, cmp_ne, dec_nz
  task automatic ex(input logic [15:0] pc, input logic [7:0] op, a, b, input logic [4:0] f,
    input logic [1:0] len, input logic [2:0] cyc, input logic [1:0] chk, input logic tk,
    input logic [15:0] tgt);
    int n;
    i_instr = {pc, op, a, b};
    i_cond = {f, 8'h10, 16'h1000};
    i_issue = 1'b1;
    @(posedge clk);
    @(negedge clk);
    i_issue = 1'b0;
    n = 1;
    while (o_done !== 1'b1) begin
      if (n > 12) begin
        n_mismatch++;
        stop_test();
      end
      @(negedge clk);
      n++;
    end
    `CHK(n[2:0], cyc)
    `CHK(o_dec.cycles, cyc)
    `CHK(o_dec.len, len)
    `CHK(o_ready, 1'b1)
    if (chk[0]) `CHK(o_dec.taken, tk)
    if (chk[0]) `CHK(o_dec.branch, 1'b1)
    if (chk[1]) `CHK(o_dec.target, tgt)
  endtask : ex

  // ==========================================================
  // Scenarios
  task automatic t_bool();
    logic [7:0] ops [9] = '{OP_ANL_BIT, OP_ANL_NBIT, OP_ORL_BIT, OP_ORL_NBIT, OP_MOV_C_BIT,
      OP_MOV_BIT_C, OP_CPL_BIT, OP_CLR_BIT, OP_SETB_BIT};
    ex(P, OP_NOP, 0, 0, 0, LEN_1, CYC_1, 0, 0, 0);
    `CHK(o_dec.branch, 1'b0)
    ex(P, OP_SPARE, 0, 0, 0, LEN_1, CYC_1, 0, 0, 0);
    ex(P, OP_CPL_C, 0, 0, 0, LEN_1, CYC_1, 0, 0, 0);
    foreach (ops[i]) begin
      ex(P, ops[i], 8'h13, 0, 0, LEN_2, CYC_2, 0, 0, 0);
      `CHK(o_dec.bit_op, 1'b1)
    end
  endtask : t_bool

  task automatic t_cond();
    ex(P, OP_JC, 8'h80, 0, 5'h10, LEN_2, CYC_3, 3, 1, rel(P, 2, 8'h80));
    ex(P, OP_JC, 8'h80, 0, 5'h00, LEN_2, CYC_2, 1, 0, 0);
    ex(P, OP_JNC, 8'h05, 0, 5'h00, LEN_2, CYC_3, 3, 1, rel(P, 2, 8'h05));
    ex(P, OP_JNC, 8'h05, 0, 5'h10, LEN_2, CYC_2, 1, 0, 0);
    ex(P, OP_JZ, 8'hF0, 0, 5'h08, LEN_2, CYC_3, 3, 1, rel(P, 2, 8'hF0));
    ex(P, OP_JNZ, 8'hF0, 0, 5'h08, LEN_2, CYC_2, 1, 0, 0);
    ex(P, OP_JB, 8'h22, 8'h7F, 5'h04, LEN_3, CYC_4, 3, 1, rel(P, 3, 8'h7F));
    ex(P, OP_JNB, 8'h22, 8'h7F, 5'h04, LEN_3, CYC_3, 1, 0, 0);
    ex(P, OP_JBC, 8'h22, 8'h01, 5'h04, LEN_3, CYC_4, 3, 1, rel(P, 3, 8'h01));
    `CHK(o_dec.bit_clear, 1'b1)
    ex(P, OP_CJNE_DIR, 8'h30, 8'h10, 5'h02, LEN_3, CYC_4, 3, 1, rel(P, 3, 8'h10));
    ex(P, OP_CJNE_IMM, 8'h30, 8'h10, 5'h00, LEN_3, CYC_3, 1, 0, 0);
    ex(P, 8'hBB, 8'h30, 8'h10, 5'h02, LEN_3, CYC_4, 3, 1, rel(P, 3, 8'h10));
    ex(P, 8'hB7, 8'h30, 8'h90, 5'h02, LEN_3, CYC_5, 3, 1, rel(P, 3, 8'h90));
    ex(P, 8'hB6, 8'h30, 8'h90, 5'h00, LEN_3, CYC_4, 1, 0, 0);
    ex(P, 8'hDA, 8'hFE, 0, 5'h01, LEN_2, CYC_3, 3, 1, rel(P, 2, 8'hFE));
    ex(P, 8'hDF, 8'hFE, 0, 5'h00, LEN_2, CYC_2, 1, 0, 0);
    ex(P, OP_DJNZ_DIR, 8'h40, 8'h20, 5'h01, LEN_3, CYC_4, 3, 1, rel(P, 3, 8'h20));
    ex(P, OP_DJNZ_DIR, 8'h40, 8'h20, 5'h00, LEN_3, CYC_3, 1, 0, 0);
  endtask : t_cond

  task automatic t_jump();
    // Next instruction starts a new page, so the upper bits must come from it
    ex(16'h17FE, 8'hF1, 8'h55, 0, 0, LEN_2, CYC_3, 2, 0, 16'h1F55);
    `CHK(o_dec.call, 1'b1)
    ex(16'h17FE, 8'hE1, 8'h55, 0, 0, LEN_2, CYC_3, 2, 0, 16'h1F55);
    ex(P, OP_LCALL, 8'hAB, 8'hCD, 0, LEN_3, CYC_4, 2, 0, 16'hABCD);
    `CHK(o_dec.call, 1'b1)
    ex(P, OP_LJMP, 8'h01, 8'h00, 0, LEN_3, CYC_4, 2, 0, 16'h0100);
    ex(P, OP_RET, 0, 0, 0, LEN_1, CYC_5, 0, 0, 0);
    `CHK(o_dec.ret, 1'b1)
    ex(P, OP_RETI, 0, 0, 0, LEN_1, CYC_5, 0, 0, 0);
    `CHK(o_dec.ret, 1'b1)
    ex(P, OP_SJMP, 8'h10, 0, 0, LEN_2, CYC_3, 2, 0, rel(P, 2, 8'h10));
    ex(P, OP_JMP_IND, 0, 0, 0, LEN_1, CYC_3, 2, 0, 16'h1010);
  endtask : t_jump

  // An issue pulse while busy must not cut the running instruction short
  task automatic t_refuse();
    ex(P, OP_NOP, 0, 0, 0, LEN_1, CYC_1, 0, 0, 0);
    i_instr = {P, OP_LCALL, 8'h12, 8'h34};
    i_issue = 1'b1;
    @(posedge clk);
    @(negedge clk);
    `CHK(o_ready, 1'b0)
    i_instr = {P, OP_NOP, 8'h00, 8'h00};
    @(negedge clk);
    i_issue = 1'b0;
    @(negedge clk);
    `CHK(o_done, 1'b0)
    @(negedge clk);
    `CHK(o_done, 1'b1)
    `CHK(o_dec.target, 16'h1234)
    @(negedge clk);
    `CHK(o_done, 1'b0)
  endtask : t_refuse

  task automatic dm(input logic ind, bo, ri, input logic [7:0] a, ps, input cmd_space_t sp,
    input logic [7:0] ba, input logic [2:0] bp, input logic [7:0] pa);
    program_status_word = ps;
    i_dreq = {1'b1, ind, bo, ri, a};
    @(negedge clk);
    `CHK(o_dmap.valid, 1'b1)
    `CHK(o_dmap.space, sp)
    `CHK(o_dmap.byte_addr, ba)
    `CHK(o_dmap.bit_op, bo)
    if (bo) `CHK(o_dmap.bit_pos, bp)
    if (ind) `CHK(o_dmap.ptr_addr, pa)
    i_dreq = '0;
  endtask : dm

  task automatic t_dmap();
    dm(0, 0, 0, 8'h45, 8'h00, CMD_LOW_RAM, 8'h45, 0, 0);
    dm(0, 0, 0, 8'h80, 8'h00, CMD_FUNC_REG, 8'h80, 0, 0);
    dm(1, 0, 1, 8'h90, 8'h18, CMD_UP_RAM, 8'h90, 0, 8'h19);
    dm(1, 0, 0, 8'h7F, 8'h08, CMD_LOW_RAM, 8'h7F, 0, 8'h08);
    dm(1, 0, 1, 8'h20, 8'h10, CMD_LOW_RAM, 8'h20, 0, 8'h11);
    dm(0, 1, 0, 8'h13, 8'h00, CMD_LOW_RAM, 8'h22, 3, 0);
    dm(0, 1, 0, 8'h7F, 8'h00, CMD_LOW_RAM, 8'h2F, 7, 0);
    dm(0, 1, 0, 8'h00, 8'h00, CMD_LOW_RAM, 8'h20, 0, 0);
    dm(0, 1, 0, 8'h8B, 8'h00, CMD_FUNC_REG, 8'h88, 3, 0);
    dm(0, 0, 0, 8'h13, 8'h00, CMD_LOW_RAM, 8'h13, 0, 0);
  endtask : t_dmap

  task automatic cm(input logic c, w, input logic [15:0] a, input logic [3:0] e);
    ctl = c;
    i_creq = {1'b1, w, a};
    @(negedge clk);
    `CHK(o_cmap.valid, 1'b1)
    `CHK({o_cmap.in_flash, o_cmap.reserved, o_cmap.code_wr, o_cmap.data_wr}, e)
    i_creq = '0;
  endtask : cm

  task automatic t_code();
    wd = 8'hC3;
    cm(0, 0, 16'h1DFF, 4'b1000);
    cm(0, 0, 16'h1E00, 4'b0100);
    cm(0, 1, 16'h0200, 4'b1001);
    cm(1, 1, 16'h0100, 4'b1010);
    @(negedge clk);
    `CHK(i_mem.flash[256], 8'hC3)
    ctl = 1'b0;
  endtask : t_code

  task automatic t_stack();
    wd = 8'h5A;
    i_push = 1'b1;
    @(negedge clk);
    i_push = 1'b0;
    `CHK(o_sp, 8'h08)
    `CHK(o_push_wr, 1'b1)
    @(negedge clk);
    `CHK(i_mem.low_ram[8], 8'h5A)
    i_pop = 1'b1;
    @(negedge clk);
    `CHK(o_sp, SP_RESET)
    i_push = 1'b1;
    @(negedge clk);
    i_push = 1'b0;
    i_pop = 1'b0;
    `CHK(o_sp, 8'h08)
  endtask : t_stack

  // ==========================================================
  // Main sequence
  initial begin
    i_rst_b = 1'b0;
    {i_issue, i_push, i_pop, ctl} = '0;
    i_instr = '0;
    i_cond = '0;
    program_status_word = '0;
    wd = '0;
    i_dreq = '0;
    i_creq = '0;
    repeat (20) @(negedge clk);
    i_rst_b = 1'b1;
    `CHK(o_sp, SP_RESET)
    `CHK({o_ready, o_done}, 2'b10)
    t_bool();
    t_cond();
    t_jump();
    t_refuse();
    t_dmap();
    t_code();
    t_stack();
    stop_test();
  end
endmodule : tb_top
